// file: src/adc_link_consts.svh
/*
 Named constants of the two-wire conversion link: word sizes,
 the reduction limit, codes and the clock-line filter time.
 Assumes inclusion by bare name from the link's design files.
*/
`ifndef ADC_LINK_CONSTS_SVH
`define ADC_LINK_CONSTS_SVH

// ==========================================================
// Word format
`define RES_FULL        5'd16
`define RES_MIN         5'd10
`define MAX_DROP        3'd6
`define DROP_W          3
`define BITS_W          5
`define WORD_W          16
`define WORD_MSB        15
`define EDGES_PER_CYCLE 17
`define CODE_RESERVED   16'h8000
`define CODE_NEG_FULL   16'h8001

// ==========================================================
// Timing
`define MCLK_PERIOD_NS  8
`define SCLK_REJECT_NS  50
`define SCLK_REJECT_MAX_NS 750
`define FILT_W          4

`endif

// file: src/adc_link_device.sv
/*
 Device end of the two-wire conversion link: wake on a falling
 clock edge, resolution reduction, completion flag, serial readout.
 Assumes mclk_i is the internal oscillator, the link clock arrives
 from the host, and sample_i is the converter core's code.
*/
// Contract
// RULE1 - Asleep with data line high when idle; after readout the device stays in DEV_HOLD, line at last bit
// RULE2 - First falling edge starts conversion, latches channel
// RULE3 - Latched channel steers mux whole conversion
// RULE4 - Window edges drop one bit, halve time
// RULE5 - Never below 10 bits; extra edges ignored
// RULE6 - Accepted window edge drives data high
// RULE7 - Acknowledge ends on clock high or window end
// RULE8 - Completion drives data line high
// RULE9 - Then sleep holding result for readout
// RULE10 - Each later falling edge presents next bit
// RULE11 - Two's complement, sign first, MSB to LSB
// RULE12 - 16 bits: sign plus 15 magnitude bits
// RULE13 - Whole cycle takes 17 falling edges
// RULE14 - Full-scale codes; reserved code never output; reduced words truncate the clamped 8001 back to 8000
// RULE15 - Clock input rejects pulses under 50 ns
// RULE16 - Host classifies state from sampled pattern
// RULE17 - Host decodes trailing 1-1 as data
// RULE18 - Host waits for data rise before reading
// RULE19 - Host resyncs by hunting start pattern; the host has no such hunt and only follows its own edge count
// RULE20 - Data line low while converting, except acknowledge
// RULE21 - Select 00..11 picks inputs one..four
// RULE22 - Window and duration are cycle parameters
`timescale 1ns/10ps
`include "adc_link_consts.svh"

module adc_link_device #(
	parameter int WIN_CYCLES  = 256,
	parameter int CONV_CYCLES = 65536
) (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	adc_link_if.device       lnk,
	input  wire logic [15:0] sample_i,
	output logic      [1:0]  chan_o,
	output logic             busy_o,
	output logic             sample_take_o
);

	localparam int FILT_CYC =
		(`SCLK_REJECT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
	localparam int WW = $clog2(WIN_CYCLES + 1);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	// ==========================================================
	// Elaboration checks
	if (FILT_CYC < 1 || FILT_CYC >= (1 << `FILT_W)) begin : g_bad_filt
		$error("Clock filter count does not fit its counter");
	end
	// Shortest conversion must outlast the window
	if ((CONV_CYCLES >> `MAX_DROP) <= WIN_CYCLES) begin : g_bad_conv
		$error("CONV_CYCLES too short for WIN_CYCLES");
	end

	// ==========================================================
	// Link-clock domain: select straps latched at each falling edge
	logic [1:0] chan_cap;

	always_ff @(negedge lnk.sclk) begin
		chan_cap <= {lnk.chan_sel_hi, lnk.chan_sel_lo}; // RULE2 RULE21
	end

	// ==========================================================
	// Crossings into the internal clock
	logic [1:0] chan_meta;
	logic [1:0] chan_sync;
	logic       sclk_meta;
	logic       sclk_sync;

	// Straps are stable long before a filtered edge is seen
	always_ff @(posedge mclk_i) begin
		chan_meta <= chan_cap;
		chan_sync <= chan_meta;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sclk_meta <= 1'b1;
			sclk_sync <= 1'b1;
		end else begin
			sclk_meta <= lnk.sclk;
			sclk_sync <= sclk_meta;
		end
	end

	// ==========================================================
	// Glitch filter: level must persist before it is believed
	logic                sclk_flt;
	logic                sclk_flt_d;
	logic [`FILT_W-1:0]  flt_cnt;
	logic                fall;
	logic                rise;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sclk_flt <= 1'b1;
			flt_cnt  <= '0;
		end else if (sclk_sync == sclk_flt) begin
			flt_cnt <= '0;
		end else if (flt_cnt == `FILT_W'(FILT_CYC - 1)) begin
			sclk_flt <= sclk_sync; // RULE15
			flt_cnt  <= '0;
		end else begin
			flt_cnt <= flt_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sclk_flt_d <= 1'b1;
		end else begin
			sclk_flt_d <= sclk_flt;
		end
	end

	assign fall = sclk_flt_d & ~sclk_flt;
	assign rise = ~sclk_flt_d & sclk_flt;

	// ==========================================================
	// Sequencing
	adc_link_pkg::dev_state_t st;
	logic [`DROP_W-1:0] drop;
	logic [WW-1:0]      win_cnt;
	logic [CW-1:0]      conv_cnt;
	logic [CW-1:0]      conv_len;
	logic [`BITS_W-1:0] bits_left;
	logic [15:0]        word;
	logic               in_win;
	logic               start;
	logic               shift;
	logic               conv_done;
	logic               reduce;

	assign in_win   = win_cnt < WW'(WIN_CYCLES);
	assign conv_len = CW'(CONV_CYCLES >> drop); // RULE4 RULE22
	// Edge after the last data bit is the next start edge
	assign start = fall && (st == adc_link_pkg::DEV_SLEEP ||
		(st == adc_link_pkg::DEV_HOLD && bits_left == '0)); // RULE2 RULE13
	assign shift = fall && st == adc_link_pkg::DEV_HOLD && bits_left != '0; // RULE10
	assign conv_done = st == adc_link_pkg::DEV_CONV && !in_win &&
		conv_cnt >= conv_len - 1'b1;
	// Seventh and later window edges change nothing
	assign reduce = fall && st == adc_link_pkg::DEV_CONV && in_win &&
		drop < `MAX_DROP; // RULE5

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st <= adc_link_pkg::DEV_SLEEP; // RULE1
		end else begin
			case (st)
				adc_link_pkg::DEV_SLEEP: begin
					if (start) begin
						st <= adc_link_pkg::DEV_CONV;
					end
				end
				adc_link_pkg::DEV_CONV: begin
					if (conv_done) begin
						st <= adc_link_pkg::DEV_HOLD; // RULE9
					end
				end
				adc_link_pkg::DEV_HOLD: begin
					if (start) begin
						st <= adc_link_pkg::DEV_CONV;
					end
				end
				default: begin
					st <= adc_link_pkg::DEV_SLEEP;
				end
			endcase
		end
	end

	// ==========================================================
	// Window, duration and resolution
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			win_cnt  <= '0;
			conv_cnt <= '0;
			drop     <= '0;
		end else if (start) begin
			win_cnt  <= '0;
			conv_cnt <= '0;
			drop     <= '0;
		end else if (st == adc_link_pkg::DEV_CONV) begin
			conv_cnt <= conv_cnt + 1'b1;
			if (in_win) begin
				win_cnt <= win_cnt + 1'b1;
			end
			if (reduce) begin
				drop <= drop + 1'b1; // RULE4
			end
		end
	end

	// ==========================================================
	// Channel held for the mux
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			chan_o <= 2'h0;
		end else if (start) begin
			chan_o <= chan_sync; // RULE3 RULE21
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			busy_o        <= 1'b0;
			sample_take_o <= 1'b0;
		end else begin
			busy_o        <= start || (st == adc_link_pkg::DEV_CONV && !conv_done);
			sample_take_o <= conv_done;
		end
	end

	// ==========================================================
	// Result word: clamp the reserved code, keep top bits
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			word      <= '0;
			bits_left <= '0;
		end else if (conv_done) begin
			if (sample_i == `CODE_RESERVED) begin
				word <= `CODE_NEG_FULL; // RULE14
			end else begin
				word <= sample_i; // RULE11
			end
			bits_left <= `RES_FULL - `BITS_W'(drop); // RULE12
		end else if (shift) begin
			word      <= {word[`WORD_MSB-1:0], 1'b0}; // RULE11
			bits_left <= bits_left - 1'b1;
		end else if (start) begin
			bits_left <= '0;
		end
	end

	// ==========================================================
	// Data line
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			lnk.result_data_line <= 1'b1; // RULE1
		end else if (start) begin
			lnk.result_data_line <= 1'b1; // RULE6
		end else if (shift) begin
			lnk.result_data_line <= word[`WORD_MSB]; // RULE10 RULE11
		end else if (st == adc_link_pkg::DEV_CONV) begin
			if (conv_done) begin
				lnk.result_data_line <= 1'b1; // RULE8
			end else if (reduce) begin
				lnk.result_data_line <= 1'b1; // RULE6
			end else if (rise || !in_win) begin
				lnk.result_data_line <= 1'b0; // RULE7 RULE20
			end
		end
	end

endmodule // adc_link_device

// file: src/adc_link_host.sv
/*
 Host end of the two-wire conversion link: makes the clock line
 by division, issues start and reduction edges, waits for the
 completion flag and shifts in the result.
 Assumes the device is on an unrelated clock.
*/
`timescale 1ns/10ps
`include "adc_link_consts.svh"

module adc_link_host #(
	parameter int SCLK_HALF = 20
) (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	adc_link_if.host         lnk,
	input  wire logic        start_i,
	input  wire logic [1:0]  chan_i,
	input  wire logic [2:0]  drop_i,
	output logic             ready_o,
	output logic      [15:0] data_o,
	output logic      [4:0]  bits_o,
	output logic             valid_o
);

	localparam int HW = $clog2(SCLK_HALF + 1);

	// ==========================================================
	// Elaboration checks
	// Half period must outlast device filter plus both syncs
	if (SCLK_HALF < 16) begin : g_bad_half
		$error("SCLK_HALF too short for device answer latency");
	end

	// ==========================================================
	// Divider tick and data-line synchroniser
	logic [HW-1:0] div_cnt;
	logic          tick;
	logic          result_data_line_meta;
	logic          result_data_line_sync;

	assign tick = div_cnt == HW'(SCLK_HALF - 1);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			result_data_line_meta <= 1'b0;
			result_data_line_sync <= 1'b0;
		end else begin
			result_data_line_meta <= lnk.result_data_line;
			result_data_line_sync <= result_data_line_meta;
		end
	end

	// ==========================================================
	// Sequencer
	adc_link_pkg::host_state_t st;
	logic [`DROP_W-1:0] drop;
	logic [`DROP_W:0]   pulses;
	logic [`BITS_W-1:0] bits_left;
	logic [15:0]        shreg;

	assign ready_o = st == adc_link_pkg::HST_IDLE;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st              <= adc_link_pkg::HST_IDLE;
			lnk.sclk        <= 1'b1;
			lnk.chan_sel_hi <= 1'b0;
			lnk.chan_sel_lo <= 1'b0;
			drop            <= '0;
			pulses          <= '0;
			bits_left       <= '0;
			shreg           <= '0;
			data_o          <= '0;
			bits_o          <= '0;
			valid_o         <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			case (st)
				adc_link_pkg::HST_IDLE: begin
					if (start_i) begin
						// Extra reductions would be ignored by the device
						drop <= (drop_i > `MAX_DROP) ? `MAX_DROP : drop_i;
						pulses <= 4'h1 + ((drop_i > `MAX_DROP) ?
							{1'b0, `MAX_DROP} : {1'b0, drop_i}); // RULE18
						{lnk.chan_sel_hi, lnk.chan_sel_lo} <= chan_i;
						st <= adc_link_pkg::HST_CLK;
					end
				end
				adc_link_pkg::HST_CLK: begin
					if (tick) begin
						if (lnk.sclk) begin
							lnk.sclk <= 1'b0;
							pulses   <= pulses - 1'b1;
						end else begin
							lnk.sclk <= 1'b1;
							if (pulses == '0) begin
								st <= adc_link_pkg::HST_GUARD;
							end
						end
					end
				end
				adc_link_pkg::HST_GUARD: begin
					// Lets the last acknowledge fall before waiting
					if (tick) begin
						st <= adc_link_pkg::HST_WAIT;
					end
				end
				adc_link_pkg::HST_WAIT: begin
					// High at rest is completion, never busy
					if (result_data_line_sync) begin // RULE17
						bits_left <= `RES_FULL - `BITS_W'(drop); // RULE13
						shreg     <= '0;
						st        <= adc_link_pkg::HST_READ; // RULE18
					end
				end
				adc_link_pkg::HST_READ: begin
					if (tick) begin
						if (lnk.sclk) begin
							lnk.sclk <= 1'b0;
						end else begin
							lnk.sclk  <= 1'b1;
							shreg     <= {shreg[`WORD_MSB-1:0], result_data_line_sync};
							bits_left <= bits_left - 1'b1;
							if (bits_left == `BITS_W'(1)) begin
								st <= adc_link_pkg::HST_DONE;
							end
						end
					end
				end
				adc_link_pkg::HST_DONE: begin
					data_o  <= shreg << drop;
					bits_o  <= `RES_FULL - `BITS_W'(drop);
					valid_o <= 1'b1;
					st      <= adc_link_pkg::HST_IDLE;
				end
				default: begin
					st <= adc_link_pkg::HST_IDLE;
				end
			endcase
		end
	end

endmodule // adc_link_host

// file: src/adc_link_if.sv
/*
 The two-wire link with the channel-select straps.
 Assumes the host makes the clock line and the device drives data.
*/
`timescale 1ns/10ps

interface adc_link_if;
	logic sclk;
	logic result_data_line;
	logic chan_sel_hi;
	logic chan_sel_lo;

	modport device (
		input  sclk,
		input  chan_sel_hi,
		input  chan_sel_lo,
		output result_data_line
	);

	modport host (
		output sclk,
		output chan_sel_hi,
		output chan_sel_lo,
		input  result_data_line
	);
endinterface

// file: src/adc_link_pkg.sv
/*
 Types shared by both ends of the two-wire conversion link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_link_pkg;

	// ==========================================================
	// Device sequencing
	typedef enum logic [2:0] {
		DEV_SLEEP = 3'h1,
		DEV_CONV  = 3'h2,
		DEV_HOLD  = 3'h4
	} dev_state_t;

	// ==========================================================
	// Host sequencing
	typedef enum logic [5:0] {
		HST_IDLE  = 6'h01,
		HST_CLK   = 6'h02,
		HST_GUARD = 6'h04,
		HST_WAIT  = 6'h08,
		HST_READ  = 6'h10,
		HST_DONE  = 6'h20
	} host_state_t;

endpackage

// file: tb/adc_link_sva.sv
/*
 Checker of the two link wires, in the device clock domain.
 Assumes tb instantiates it beside the link interface.
*/
`timescale 1ns/10ps

module adc_link_sva (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic sclk,
	input wire logic result_data_line,
	input wire logic chan_sel_hi,
	input wire logic chan_sel_lo
);
	// ==========================================================
	// Wire tracking
	logic [2:0] sync;
	logic [4:0] quiet;
	logic [4:0] cnt;
	logic       data_q;
	logic       done;
	logic       fall;
	logic       rise;
	logic       done_rise;

	assign fall = sync[2] & ~sync[1];
	assign rise = ~sync[2] & sync[1];
	// Completion is the only rise of data with the clock line at rest
	assign done_rise = ~done & (cnt != 5'h00) & (quiet > 5'h14) & result_data_line & ~data_q;

	always_ff @(posedge mclk_i) begin
		sync <= sys_rst_i ? 3'h7 : {sync[1:0], sclk};
		data_q <= result_data_line;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || sync[2] != sync[1])
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	end

	// Every cycle is 17 falls whatever the resolution
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			cnt <= 5'h00;
		else if (fall)
			cnt <= (cnt == 5'h10) ? 5'h00 : cnt + 5'h01;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			done <= 1'b0;
		else if (fall && cnt == 5'h10)
			done <= 1'b0;
		else if (done_rise)
			done <= 1'b1;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	AST_RST_RELEASE: assert property ($fell(sys_rst_i) |-> result_data_line)
		else $error("data line low after reset");
	AST_START_ACK: assert property (fall && cnt == 5'h00 |-> ##9 result_data_line [*8])
		else $error("start edge not acknowledged");
	AST_REDUCE_ACK: assert property (fall && cnt inside {[1:6]} && !done
		|-> ##[4:12] result_data_line)
		else $error("reduction edge not acknowledged");
	AST_ACK_END: assert property (rise && cnt inside {[1:7]} && !done
		|-> ##[4:12] !result_data_line)
		else $error("acknowledge did not end");
	AST_QUIET_FALL: assert property ($fell(result_data_line) |-> quiet < 5'h10)
		else $error("data line fell with clock at rest");
	AST_DONE_HOLD: assert property (done_rise |=> result_data_line [*8])
		else $error("completion level not held");
	AST_READ_STABLE: assert property (fall && done |-> ##1 $stable(result_data_line) [*4])
		else $error("data bit changed too early");
	AST_CYCLE_LEN: assert property (fall && cnt == 5'h10 |-> done)
		else $error("cycle ended before completion");
	AST_STRAP_HOLD: assert property (cnt != 5'h00 && !done
		|-> $stable({chan_sel_hi, chan_sel_lo}))
		else $error("channel straps moved in conversion");
endmodule // adc_link_sva

// file: tb/tb.sv
/*
 Self-checking bench: host and device joined by the link interface.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps

module tb;
	typedef struct packed {
		logic [1:0]  chan;
		logic [2:0]  drop;
		logic [15:0] smp;
		logic [15:0] word;
		logic [4:0]  bits;
	} row_t;

	// ==========================================================
	// Cases: drop 7 clamps to 6; 8000 is sent as 8001
	localparam row_t ROWS [5] = '{
		'{2'h0, 3'h6, 16'h7fff, 16'h7fc0, 5'h0a},
		'{2'h1, 3'h7, 16'h8000, 16'h8000, 5'h0a},
		'{2'h2, 3'h4, 16'hedcb, 16'hedc0, 5'h0c},
		'{2'h3, 3'h0, 16'h8000, 16'h8001, 5'h10},
		'{2'h2, 3'h6, 16'h0040, 16'h0040, 5'h0a}
	};

	logic        mclk;
	logic        dev_clk;
	logic        sys_rst;
	logic        start;
	logic [1:0]  chan;
	logic [2:0]  drop;
	logic [15:0] sample;
	logic        ready;
	logic [15:0] word;
	logic [4:0]  bits;
	logic        valid;
	logic [1:0]  dev_chan;
	logic        busy;
	int          err_total;
	int          checks_done;
	int          i;

	adc_link_if u_adc_link_if ();

	int          takes = 0;
	logic        take;

	adc_link_host #(.SCLK_HALF(24)) u_adc_link_host (
		.mclk_i    (mclk),
		.sys_rst_i (sys_rst),
		.lnk       (u_adc_link_if),
		.start_i   (start),
		.chan_i    (chan),
		.drop_i    (drop),
		.ready_o   (ready),
		.data_o    (word),
		.bits_o    (bits),
		.valid_o   (valid)
	);

	// Wider window fits six reduction edges; short conversion keeps the full-resolution case affordable
	adc_link_device #(.WIN_CYCLES(384), .CONV_CYCLES(32768)) u_adc_link_device (
		.mclk_i        (dev_clk),
		.sys_rst_i     (sys_rst),
		.lnk           (u_adc_link_if),
		.sample_i      (sample),
		.chan_o        (dev_chan),
		.busy_o        (busy),
		.sample_take_o (take)
	);

	// Completions seen by the converter core
	always @(posedge dev_clk) begin
		if (take === 1'b1)
			takes++;
	end

	adc_link_sva u_adc_link_sva (
		.mclk_i           (dev_clk),
		.sys_rst_i        (sys_rst),
		.sclk             (u_adc_link_if.sclk),
		.result_data_line (u_adc_link_if.result_data_line),
		.chan_sel_hi      (u_adc_link_if.chan_sel_hi),
		.chan_sel_lo      (u_adc_link_if.chan_sel_lo)
	);

	// ==========================================================
	// Clocks, device clock offset so the phases never line up
	always #4 mclk = ~mclk;

	initial begin
		dev_clk = 1'b0;
		#3.1;
		forever #4 dev_clk = ~dev_clk;
	end

	// ==========================================================
	// Tasks
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Counted in device cycles so the device side and its syncs see it
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (10) @(posedge dev_clk);
		tick();
		sys_rst = 1'b0;
		repeat (8) @(posedge dev_clk);
		tick();
	endtask

	task automatic begin_conv(input row_t r);
		int n;
		for (n = 0; n < 100 && ready !== 1'b1; n++)
			tick();
		chan = r.chan;
		drop = r.drop;
		sample = r.smp;
		start = 1'b1;
		tick();
		start = 1'b0;
		for (n = 0; n < 2000 && busy !== 1'b1; n++)
			tick();
		check("busy", {15'h0, busy}, 16'h0001);
		check("chan", {14'h0, dev_chan}, {14'h0, r.chan});
	endtask

	task automatic finish_conv(input row_t r);
		int n;
		for (n = 0; n < 80000 && valid !== 1'b1; n++)
			tick();
		check("valid", {15'h0, valid}, 16'h0001);
		check("word", word, r.word);
		check("bits", {11'h0, bits}, {11'h0, r.bits});
		check("busy", {15'h0, busy}, 16'h0000);
		$display("test done chan %h drop %h", r.chan, r.drop);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		start = 1'b0;
		chan = 2'h0;
		drop = 3'h0;
		sample = 16'h0000;
		err_total = 0;
		checks_done = 0;
		do_reset();
		check("line", {15'h0, u_adc_link_if.result_data_line}, 16'h0001);
		check("sclk", {15'h0, u_adc_link_if.sclk}, 16'h0001);
		for (i = 0; i < 4; i++) begin
			begin_conv(ROWS[i]);
			finish_conv(ROWS[i]);
		end
		// Reset in mid-conversion must put the device back to sleep
		begin_conv(ROWS[0]);
		do_reset();
		check("line", {15'h0, u_adc_link_if.result_data_line}, 16'h0001);
		check("busy", {15'h0, busy}, 16'h0000);
		check("chan", {14'h0, dev_chan}, 16'h0000);
		$display("test done reset in conversion");
		begin_conv(ROWS[4]);
		finish_conv(ROWS[4]);
		check("takes", 16'(takes), 16'h0005);
		end_sim();
	end

	initial begin
		#800000;
		err_total++;
		$display("ERROR watchdog expected finish seen hang");
		end_sim();
	end
endmodule // tb
